// ===== common/acs_consts.svh
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ==========================================================
// channel select codes
`define ACS_SEL_PEAK      5'h06
`define ACS_SEL_OUT_BASE  5'h08
`define ACS_NUM_OUTPUTS   24
`define ACS_NUM_GROUPS    8
`define ACS_LAST_GROUP    3'h7
`define ACS_NO_OUTPUT     2'h3

// ==========================================================
// timing
`define ACS_CLK_MHZ       25
`define ACS_CONV_TIME_NS  4000
`define ACS_CONV_CYC      ((`ACS_CONV_TIME_NS * `ACS_CLK_MHZ + 999) / 1000)
// blanking time in us, code 15 in the top slice down to code 0
`define ACS_BLANK_US_TABLE {12'd4000, 12'd3000, 12'd2000, 12'd1500, 12'd1200, 12'd1000, \
                            12'd800, 12'd500, 12'd300, 12'd200, 12'd150, 12'd80, \
                            12'd50, 12'd30, 12'd20, 12'd100}

`endif

// ===== common/acs_pkg.sv
`default_nettype none
// ==========================================================
// shared types
package acs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_CYC,
        ST_WAIT_ON,
        ST_BLANK,
        ST_CONVERT
    } acs_state_t;

    typedef struct packed {
        logic       start;
        logic [4:0] mux;
    } acs_conv_req_t;

    typedef struct packed {
        logic [2:0] grp;
        logic [1:0] sub;
    } acs_scan_pos_t;

endpackage : acs_pkg

`default_nettype wire

// ===== verilog/acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.svh"

module acs_sequencer
    import acs_pkg::*;
#(
    parameter int BLANK_CYC_PER_US = `ACS_CLK_MHZ
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        SEL_WR,
    input  wire logic [4:0]  SEL_WDATA,
    input  wire logic        RESULT_RD,
    input  wire logic        FAULT_CLR,
    input  wire logic [23:0] OUT_EN,
    input  wire logic [7:0]  GRP_ON,
    input  wire logic        DIM_START,
    input  wire logic [3:0]  BLANK_CODE,
    input  wire logic        CONV_DONE,
    input  wire logic [7:0]  CONV_CODE,
    output logic [4:0]       SEL,
    output logic [7:0]       RESULT,
    output logic             DONE_FLAG,
    output logic             TIMING_ERR_FLAG,
    output logic             CONV_START,
    output logic [4:0]       CONV_MUX,
    output logic             BUSY
);

    // ==========================================================
    // helpers
    function automatic logic [1:0] first_en(input logic [23:0] en, input logic [2:0] g,
                                            input logic [1:0] from);
        logic [1:0] r;
        r = `ACS_NO_OUTPUT;
        for (int k = 2; k >= 0; k--) begin
            if (2'(k) >= from && en[5'(g) * 5'd3 + 5'(k)]) begin
                r = 2'(k);
            end
        end
        return r;
    endfunction : first_en

    function automatic logic [4:0] out_code(input acs_scan_pos_t p);
        return `ACS_SEL_OUT_BASE + 5'(p.grp) * 5'd3 + 5'(p.sub);
    endfunction : out_code

    function automatic logic [19:0] blank_cyc(input logic [3:0] code);
        logic [191:0] tbl;
        logic [11:0]  us;
        tbl = `ACS_BLANK_US_TABLE;
        us  = tbl[12 * code +: 12];
        return 20'(us) * 20'(BLANK_CYC_PER_US);
    endfunction : blank_cyc

    // ==========================================================
    // state
    acs_state_t    state_ff,  nxt_state;
    acs_conv_req_t req_ff,    nxt_req;
    acs_scan_pos_t pos_ff,    nxt_pos;
    logic [4:0]    sel_ff,    nxt_sel;
    logic [7:0]    result_ff, nxt_result;
    logic [7:0]    peak_ff,   nxt_peak;
    logic          done_ff,   nxt_done;
    logic          err_ff,    nxt_err;
    logic [19:0]   blank_ff,  nxt_blank;
    logic [19:0]   period_ff, nxt_period;
    logic          seen_ff,   nxt_seen;
    logic          busy_ff,   nxt_busy;
    logic [7:0]    grp_on_prev_ff;

    logic [7:0]    rise;
    logic [19:0]   min_period;
    logic          complete;
    logic          start;
    logic [4:0]    start_sel;
    logic [4:0]    idx;
    logic [1:0]    nsub;

    assign rise       = GRP_ON & ~grp_on_prev_ff;
    assign min_period = blank_cyc(BLANK_CODE) + 20'(3 * `ACS_CONV_CYC);
    assign complete   = (state_ff == ST_CONVERT) && CONV_DONE;
    // completion beats a read in the same cycle, so the fresh result is not lost
    assign start      = SEL_WR || (RESULT_RD && !complete);
    assign start_sel  = SEL_WR ? SEL_WDATA : sel_ff;
    // busy is registered from the next state so the pin never shows a decode glitch
    assign nxt_busy   = (nxt_state != ST_IDLE);

    // ==========================================================
    // next state
    always_comb begin
        nxt_state  = state_ff;
        nxt_req    = '{start: 1'b0, mux: req_ff.mux};
        nxt_pos    = pos_ff;
        nxt_sel    = sel_ff;
        nxt_result = result_ff;
        nxt_peak   = peak_ff;
        nxt_done   = done_ff;
        nxt_err    = err_ff & ~FAULT_CLR;
        nxt_blank  = blank_ff;
        nxt_period = (period_ff == 20'hfffff) ? period_ff : period_ff + 20'd1;
        nxt_seen   = seen_ff;
        idx        = start_sel - `ACS_SEL_OUT_BASE;
        nsub       = first_en(OUT_EN, pos_ff.grp, pos_ff.sub + 2'd1);

        case (state_ff)
            ST_IDLE: begin
            end
            ST_WAIT_CYC: begin
                // auto scan: groups with every output off are skipped
                if (first_en(OUT_EN, pos_ff.grp, 2'd0) == `ACS_NO_OUTPUT) begin
                    if (pos_ff.grp == `ACS_LAST_GROUP) begin
                        nxt_result = peak_ff;
                        nxt_done   = 1'b1;
                        nxt_state  = ST_IDLE;
                    end else begin
                        nxt_pos.grp = pos_ff.grp + 3'd1;
                    end
                end else if (DIM_START) begin
                    nxt_state = rise[pos_ff.grp] ? ST_BLANK : ST_WAIT_ON;
                    nxt_blank = 20'd0;
                end
            end
            ST_WAIT_ON: begin
                if (rise[pos_ff.grp]) begin
                    nxt_state = ST_BLANK;
                    nxt_blank = 20'd0;
                end
            end
            ST_BLANK: begin
                nxt_blank = blank_ff + 20'd1;
                if (blank_ff + 20'd1 >= blank_cyc(BLANK_CODE)) begin
                    nxt_state = ST_CONVERT;
                    if (sel_ff == `ACS_SEL_PEAK) begin
                        nxt_pos.sub = first_en(OUT_EN, pos_ff.grp, 2'd0);
                    end
                    nxt_req = '{start: 1'b1, mux: out_code('{grp: pos_ff.grp,
                               sub: (sel_ff == `ACS_SEL_PEAK) ?
                                    first_en(OUT_EN, pos_ff.grp, 2'd0) : pos_ff.sub})};
                end
            end
            ST_CONVERT: begin
                if (CONV_DONE) begin
                    if (sel_ff == `ACS_SEL_PEAK) begin
                        if (CONV_CODE > peak_ff) begin
                            nxt_peak = CONV_CODE;
                        end
                        if (nsub != `ACS_NO_OUTPUT && pos_ff.sub != `ACS_NO_OUTPUT) begin
                            nxt_pos.sub = nsub;
                            nxt_req     = '{start: 1'b1,
                                            mux: out_code('{grp: pos_ff.grp, sub: nsub})};
                        end else if (pos_ff.grp == `ACS_LAST_GROUP) begin
                            nxt_result = (CONV_CODE > peak_ff) ? CONV_CODE : peak_ff;
                            nxt_done   = 1'b1;
                            nxt_state  = ST_IDLE;
                        end else begin
                            nxt_pos   = '{grp: pos_ff.grp + 3'd1, sub: 2'd0};
                            nxt_state = ST_WAIT_CYC;
                        end
                    end else begin
                        nxt_result = CONV_CODE;
                        nxt_done   = 1'b1;
                        nxt_state  = ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase

        // dimming period check while measuring
        if (state_ff != ST_IDLE && DIM_START) begin
            nxt_period = 20'd0;
            nxt_seen   = 1'b1;
            if (seen_ff && (period_ff + 20'd1 < min_period)) begin
                nxt_err   = 1'b1;
                nxt_state = ST_IDLE;
                nxt_req   = '{start: 1'b0, mux: req_ff.mux};
            end
        end

        // a new start aborts whatever runs
        if (start) begin
            nxt_sel    = start_sel;
            nxt_done   = 1'b0;
            nxt_peak   = 8'h00;
            nxt_period = 20'd0;
            nxt_seen   = 1'b0;
            nxt_blank  = 20'd0;
            nxt_pos    = '{grp: 3'd0, sub: 2'd0};
            if (start_sel == `ACS_SEL_PEAK) begin
                nxt_state = ST_WAIT_CYC;
                nxt_req   = '{start: 1'b0, mux: req_ff.mux};
            end else if (start_sel >= `ACS_SEL_OUT_BASE) begin
                nxt_pos = '{grp: 3'(idx / 5'd3), sub: 2'(idx % 5'd3)};
                if (OUT_EN[idx]) begin
                    nxt_state = ST_WAIT_ON;
                    nxt_req   = '{start: 1'b0, mux: req_ff.mux};
                end else begin
                    nxt_state = ST_CONVERT;
                    nxt_req   = '{start: 1'b1, mux: start_sel};
                end
            end else begin
                // 07h converts like a fixed tap; its code means nothing
                nxt_state = ST_CONVERT;
                nxt_req   = '{start: 1'b1, mux: start_sel};
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_ff       <= ST_IDLE;
            req_ff         <= '{start: 1'b0, mux: 5'h00};
            pos_ff         <= '{grp: 3'd0, sub: 2'd0};
            sel_ff         <= 5'h00;
            result_ff      <= 8'h00;
            peak_ff        <= 8'h00;
            done_ff        <= 1'b0;
            err_ff         <= 1'b0;
            blank_ff       <= 20'd0;
            period_ff      <= 20'd0;
            seen_ff        <= 1'b0;
            busy_ff        <= 1'b0;
            grp_on_prev_ff <= 8'h00;
        end else begin
            state_ff       <= nxt_state;
            req_ff         <= nxt_req;
            pos_ff         <= nxt_pos;
            sel_ff         <= nxt_sel;
            result_ff      <= nxt_result;
            peak_ff        <= nxt_peak;
            done_ff        <= nxt_done;
            err_ff         <= nxt_err;
            blank_ff       <= nxt_blank;
            period_ff      <= nxt_period;
            seen_ff        <= nxt_seen;
            busy_ff        <= nxt_busy;
            grp_on_prev_ff <= GRP_ON;
        end
    end

    assign SEL             = sel_ff;
    assign RESULT          = result_ff;
    assign DONE_FLAG       = done_ff;
    assign TIMING_ERR_FLAG = err_ff;
    assign CONV_START      = req_ff.start;
    assign CONV_MUX        = req_ff.mux;
    assign BUSY            = busy_ff;

endmodule : acs_sequencer

`default_nettype wire

// ===== verification/acs_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.svh"
module acs_sequencer_assertions
    import acs_pkg::*;
#(
    parameter int BLANK_CYC_PER_US = `ACS_CLK_MHZ
) (
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        SEL_WR,
    input wire logic [4:0]  SEL_WDATA,
    input wire logic        RESULT_RD,
    input wire logic        FAULT_CLR,
    input wire logic [23:0] OUT_EN,
    input wire logic        DIM_START,
    input wire logic        CONV_DONE,
    input wire logic [7:0]  CONV_CODE,
    input wire logic [4:0]  SEL,
    input wire logic [7:0]  RESULT,
    input wire logic        DONE_FLAG,
    input wire logic        TIMING_ERR_FLAG,
    input wire logic        CONV_START,
    input wire logic [4:0]  CONV_MUX,
    input wire logic        BUSY
);
    // ==========================================
    // port relations
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // direct channels start the converter on the very next cycle
    sequence s_start_now;
        ##1 CONV_START && CONV_MUX == $past(SEL_WDATA);
    endsequence
    property p_sel_clear;
        SEL_WR |=> !DONE_FLAG && BUSY && SEL == $past(SEL_WDATA);
    endproperty
    a_sel_clear: assert property (p_sel_clear) else $error("select write not taken");
    property p_fixed_tap;
        SEL_WR && SEL_WDATA < 5'h06 |-> s_start_now;
    endproperty
    a_fixed_tap: assert property (p_fixed_tap) else $error("fixed tap not started");
    property p_out_off;
        SEL_WR && SEL_WDATA >= 5'h08 && !OUT_EN[SEL_WDATA - 5'h08] |-> s_start_now;
    endproperty
    a_out_off: assert property (p_out_off) else $error("off output not started");
    property p_peak_waits;
        SEL_WR && SEL_WDATA == `ACS_SEL_PEAK |=> !CONV_START;
    endproperty
    a_peak_waits: assert property (p_peak_waits) else $error("scan did not wait");
    property p_read_restart;
        RESULT_RD && !SEL_WR && !CONV_DONE |=> !DONE_FLAG && BUSY;
    endproperty
    a_read_restart: assert property (p_read_restart) else $error("read no restart");
    property p_done_set;
        BUSY && CONV_DONE && !SEL_WR && !RESULT_RD && !DIM_START && SEL != `ACS_SEL_PEAK
            |=> DONE_FLAG && !BUSY && RESULT == $past(CONV_CODE);
    endproperty
    a_done_set: assert property (p_done_set) else $error("result not stored");
    property p_result_hold;
        !CONV_DONE && SEL != `ACS_SEL_PEAK |=> $stable(RESULT);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved");
    property p_done_hold;
        !CONV_DONE && !SEL_WR && !RESULT_RD && SEL != `ACS_SEL_PEAK |=> $stable(DONE_FLAG);
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done flag moved");
    property p_err_clear;
        FAULT_CLR && !DIM_START |=> !TIMING_ERR_FLAG;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error not cleared");
    property p_err_stops;
        $rose(TIMING_ERR_FLAG) |-> !BUSY && !DONE_FLAG;
    endproperty
    a_err_stops: assert property (p_err_stops) else $error("error did not stop");
endmodule : acs_sequencer_assertions
bind acs_sequencer acs_sequencer_assertions #(.BLANK_CYC_PER_US(BLANK_CYC_PER_US)) chk_u (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .SEL_WR(SEL_WR), .SEL_WDATA(SEL_WDATA),
    .RESULT_RD(RESULT_RD), .FAULT_CLR(FAULT_CLR), .OUT_EN(OUT_EN), .DIM_START(DIM_START),
    .CONV_DONE(CONV_DONE), .CONV_CODE(CONV_CODE), .SEL(SEL), .RESULT(RESULT),
    .DONE_FLAG(DONE_FLAG), .TIMING_ERR_FLAG(TIMING_ERR_FLAG), .CONV_START(CONV_START),
    .CONV_MUX(CONV_MUX), .BUSY(BUSY));
`default_nettype wire

// ===== verification/acs_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_conv_model
    import acs_pkg::*;
#(
    parameter int LAT = 20
) (
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [4:0] mux,
    output logic            done,
    output logic [7:0]      code
);
    // ==========================================
    // converter: a new start aborts the old one
    int         cnt_ff = 0;
    logic [7:0] code_ff = 8'h00;
    always @(posedge clk) begin
        if (start) begin
            cnt_ff  <= LAT;
            code_ff <= 8'h40 + {3'h0, mux};
        end else if (cnt_ff > 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    assign done = (cnt_ff == 1);
    // code is only valid with done, garbage otherwise
    // raw code only; the host scales it by offset and slope
    assign code = done ? code_ff : ~code_ff;
endmodule : acs_conv_model
`default_nettype wire

// ===== verification/acs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb
    import acs_pkg::*;
;
    logic        ref_clk = 1'b0, rst_n = 1'b0, sel_wr = 1'b0, result_rd = 1'b0;
    logic        fault_clr = 1'b0, dim_start = 1'b0, conv_done, done_flag, err_flag;
    logic        conv_start, busy;
    logic [4:0]  sel_wdata = 5'h00, sel, conv_mux;
    logic [7:0]  grp_on = 8'h00, conv_code, result;
    logic [23:0] out_en = 24'h000000;
    logic [3:0]  blank_code = 4'h1;
    int          mismatches = 0, tests_run = 0, cyc = 0, dim_per = 400, dim_cnt = 0;
    int          on_wait = 0;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
    initial forever #20 ref_clk = ~ref_clk;
    acs_sequencer #(.BLANK_CYC_PER_US(1)) dut_u (
        .REF_CLK(ref_clk), .RST_N(rst_n), .SEL_WR(sel_wr), .SEL_WDATA(sel_wdata),
        .RESULT_RD(result_rd), .FAULT_CLR(fault_clr), .OUT_EN(out_en), .GRP_ON(grp_on),
        .DIM_START(dim_start), .BLANK_CODE(blank_code), .CONV_DONE(conv_done),
        .CONV_CODE(conv_code), .SEL(sel), .RESULT(result), .DONE_FLAG(done_flag),
        .TIMING_ERR_FLAG(err_flag), .CONV_START(conv_start), .CONV_MUX(conv_mux),
        .BUSY(busy));
    acs_conv_model conv_u (.clk(ref_clk), .start(conv_start), .mux(conv_mux),
        .done(conv_done), .code(conv_code));
    // ==========================================
    // dimming cycle: all groups switch on together
    always @(negedge ref_clk) begin
        dim_cnt   <= (dim_cnt + 1 >= dim_per) ? 0 : dim_cnt + 1;
        dim_start <= (dim_cnt == 0);
        grp_on    <= (dim_cnt < dim_per / 2) ? 8'hff : 8'h00;
    end
    localparam logic [2:0] STB_SEL = 3'b001;
    localparam logic [2:0] STB_RD  = 3'b010;
    localparam logic [2:0] STB_CLR = 3'b100;
    // one strobe per call; the low cycle between calls keeps back to back calls apart
    task automatic pulse(input logic [2:0] which);
        @(negedge ref_clk);
        {fault_clr, result_rd, sel_wr} = which;
        @(negedge ref_clk);
        {fault_clr, result_rd, sel_wr} = 3'b000;
    endtask : pulse
    task automatic sel_write(input logic [4:0] code);
        sel_wdata = code;
        pulse(STB_SEL);
    endtask : sel_write
    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (done_flag !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(done_flag, 1'b1)
    endtask : wait_done
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    // long scan takes about two dimming cycles twice
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    // ==========================================
    // tests
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        `CHK({sel, result, done_flag, busy}, 15'h0000)
        for (int c = 0; c < 6; c++) begin // reserved 07h is never written
            sel_write(5'(c));
            `CHK(done_flag, 1'b0)
            wait_done(100);
            `CHK(result, 8'h40 + 8'(c))
        end
        $display("test fixed taps ended");
        pulse(STB_RD);
        `CHK(done_flag, 1'b0)
        wait_done(100);
        repeat (30) @(negedge ref_clk);
        `CHK({done_flag, result}, 9'h145)
        sel_write(5'h01);
        sel_write(5'h02);
        wait_done(100);
        `CHK(result, 8'h42)
        $display("test restart and abort ended");
        sel_write(5'h1f);
        wait_done(100);
        `CHK(result, 8'h5f)
        out_en = 24'h000081;
        // longest blanking code of the short ones: 100 us, one cycle per us here
        blank_code = 4'h0;
        repeat (dim_per) @(negedge ref_clk);
        sel_write(5'h08);
        @(posedge grp_on[0]);
        on_wait = 0;
        while (conv_start !== 1'b1 && on_wait < 1000) begin
            @(negedge ref_clk);
            on_wait++;
        end
        `CHK(on_wait >= 100 && on_wait < 1000, 1'b1)
        wait_done(1000);
        `CHK(result, 8'h48)
        blank_code = 4'h1;
        $display("test outputs ended");
        // A0 and C1 enabled, the rest skipped
        sel_write(5'h06);
        wait_done(5000);
        `CHK(result, 8'h4f)
        pulse(STB_RD);
        `CHK({done_flag, busy}, 2'b01)
        wait_done(5000);
        `CHK(result, 8'h4f)
        $display("test peak scan ended");
        dim_per = 100;
        sel_write(5'h06);
        repeat (400) @(negedge ref_clk);
        `CHK({err_flag, busy, done_flag}, 3'b100)
        pulse(STB_CLR);
        `CHK(err_flag, 1'b0)
        $display("test timing error ended");
        // reset in the middle of a conversion
        sel_write(5'h01);
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        `CHK({sel, result, done_flag, err_flag}, 15'h0000)
        `CHK({conv_start, conv_mux, busy}, 7'h00)
        $display("test reset ended");
        finish_test();
    end
endmodule : acs_sequencer_tb
`default_nettype wire
